//--- design/sfac_defines.vh
// Constants for the sectored flash access controller
`ifndef SFAC_DEFINES_VH
`define SFAC_DEFINES_VH

// =====================================================================
// Array geometry
`define SFAC_FLASH_KB       17'h00020
`define SFAC_ADDR_TOP       17'h10000
`define SFAC_KB_BYTES       17'h00400
`define SFAC_SEC0_BASE      16'hf000
`define SFAC_SEC1_BASE      16'he000
`define SFAC_SMALL_KB       17'h00008
`define SFAC_TINY_KB        17'h00004

// =====================================================================
// Register indices (byte address is four times the index)
`define SFAC_IDX_FCSR       8'h2b
`define SFAC_IDX_ADDRL      8'h60
`define SFAC_IDX_ADDRH      8'h61
`define SFAC_IDX_DATA       8'h62
`define SFAC_IDX_OPT        8'h63
`define SFAC_IDX_INFO       8'h64
`define SFAC_RESET_BYTE     8'h00

// =====================================================================
// Control/status fields
`define SFAC_BIT_PROG       0
`define SFAC_BIT_SERASE     1
`define SFAC_BIT_MERASE     2
`define SFAC_BIT_OPTPROG    3
`define SFAC_BIT_BUSY       4
`define SFAC_BIT_ERR        5
`define SFAC_BIT_UNLOCK     6
`define SFAC_KEY1           8'h56
`define SFAC_KEY2           8'hae
`define SFAC_BIT_PROTECT    0

// =====================================================================
// Programming mode pin codes
`define SFAC_MODE_SOCKET    2'h0
`define SFAC_MODE_ICP       2'h1
`define SFAC_MODE_IAP       2'h2
`define SFAC_MODE_ICT       2'h3

`endif

//--- design/sfac_sector_check.v
// Sector decode and permission check for one flash address
`timescale 1ns/1ps
`include "sfac_defines.vh"

module sfac_sector_check (
    // Request
    input  wire [15:0] addr,
    input  wire [1:0]  mode,
    input  wire        protect,
    // Result
    output reg  [2:0]  sector,
    output reg         in_array,
    output reg         allowed
);

    // =================================================================
    // Array bounds
    wire [16:0] base_full = `SFAC_ADDR_TOP
                          - (`SFAC_KB_BYTES * `SFAC_FLASH_KB);
    wire [15:0] base      = base_full[15:0];
    wire        two_secs  = (`SFAC_FLASH_KB >= `SFAC_SMALL_KB);
    wire        three_sec = (`SFAC_FLASH_KB > `SFAC_SMALL_KB);

    // Sector select and permission
    always @* begin
        sector   = 3'h0;
        in_array = 1'b0;
        allowed  = 1'b0;
        if (addr >= `SFAC_SEC0_BASE) begin
            sector   = 3'h1;                      // [R8] [R7]
            in_array = 1'b1;
        end else if (two_secs && addr >= `SFAC_SEC1_BASE) begin
            sector   = 3'h2;                      // [R7] [R6]
            in_array = 1'b1;
        end else if (three_sec && addr >= base) begin
            sector   = 3'h4;                      // [R6]
            in_array = 1'b1;
        end
        case (mode)
            `SFAC_MODE_SOCKET: allowed = in_array;         // [R4]
            `SFAC_MODE_ICP:    allowed = in_array;         // [R4]
            `SFAC_MODE_IAP:    allowed = in_array & ~sector[0]; // [R5]
            default:           allowed = 1'b0;
        endcase
        if (protect) begin
            allowed = 1'b0;
        end
    end

endmodule

//--- design/sfac_flash_ctrl.v
// APB access and protection controller for the sectored program flash
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sfac_defines.vh"

// Notes on behaviour
// [R1] Erase either the whole array or a single sector.
// [R2] Each program command writes exactly one byte location.
// [R3] Sector erase and program touch only the selected sector.
// [R4] Socket and in-circuit modes may change every sector and option byte.
// [R5] In-application mode may change all sectors except sector 0.
// [R6] Sector count follows array size: 4K one, 8K two, larger three.
// [R7] Sectors 0 and 1 are 4 Kbyte each at the top of memory.
// [R8] Sector 0 spans F000h-FFFFh and holds reset and interrupt vectors.
// [R9] Test mode runs user patterns from RAM, flash changes refused.
// [R10] Two-key unlock on control register guards every program or erase.
// [R11] Clearing read-out protection first erases the whole array.
// [R12] In-application requests aimed at sector 0 are dropped and flagged.
module sfac_flash_ctrl (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Programming mode pins
    input  wire [1:0]  prog_mode,
    // Flash macro
    input  wire        flash_done,
    output reg  [15:0] flash_addr,
    output reg  [7:0]  flash_wdata,
    output reg  [2:0]  flash_sector,
    output reg         flash_prog,
    output reg         flash_erase,
    output reg         flash_erase_all,
    output reg         flash_opt_prog,
    output reg  [7:0]  flash_opt_data,
    // System
    output reg         ram_exec,
    output reg         readout_protect_option
);

    // =================================================================
    // States
    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_PROG  = 5'h02;
    localparam [4:0] ST_SERA  = 5'h04;
    localparam [4:0] ST_MERA  = 5'h08;
    localparam [4:0] ST_OPTW  = 5'h10;

    // =================================================================
    // Storage
    reg  [4:0] state;
    reg  [4:0] next_state;
    reg  [7:0] addr_lo;
    reg  [7:0] addr_hi;
    reg  [7:0] wr_data;
    reg  [7:0] opt_pending;
    reg  [7:0] opt_current;
    reg  [1:0] key_stage;
    reg        err_flag;
    reg        opt_after_erase;

    // =================================================================
    // Bus decode
    wire [9:0] idx      = paddr[11:2];
    wire       access   = psel & penable;
    wire       complete = access & pready;
    wire       wr_en    = complete & pwrite;
    wire       hit_fcsr = (idx == {2'h0, `SFAC_IDX_FCSR});
    wire       hit_al   = (idx == {2'h0, `SFAC_IDX_ADDRL});
    wire       hit_ah   = (idx == {2'h0, `SFAC_IDX_ADDRH});
    wire       hit_dat  = (idx == {2'h0, `SFAC_IDX_DATA});
    wire       hit_opt  = (idx == {2'h0, `SFAC_IDX_OPT});
    wire       hit_info = (idx == {2'h0, `SFAC_IDX_INFO});
    wire       mapped   = hit_fcsr | hit_al | hit_ah | hit_dat
                        | hit_opt | hit_info;
    wire       busy     = ~state[0];
    wire       unlocked = (key_stage == 2'h2);
    wire [7:0] wbyte    = pwdata[7:0];

    // Command decode from an unlocked control write
    wire       cmd_wr   = wr_en & hit_fcsr & unlocked & ~busy;
    wire       c_prog   = cmd_wr & wbyte[`SFAC_BIT_PROG];
    wire       c_sera   = cmd_wr & wbyte[`SFAC_BIT_SERASE];
    wire       c_mera   = cmd_wr & wbyte[`SFAC_BIT_MERASE];
    wire       c_optw   = cmd_wr & wbyte[`SFAC_BIT_OPTPROG];
    wire       any_cmd  = c_prog | c_sera | c_mera | c_optw;

    // =================================================================
    // Sector and permission check
    wire [2:0] chk_sector;
    wire       chk_in;
    wire       chk_ok;
    wire       protect = opt_current[`SFAC_BIT_PROTECT];

    sfac_sector_check u_check (
        .addr     ({addr_hi, addr_lo}),
        .mode     (prog_mode),
        .protect  (protect),
        .sector   (chk_sector),
        .in_array (chk_in),
        .allowed  (chk_ok)
    );

    // Whole-array and option changes need an external-tool mode
    wire tool_mode = (prog_mode == `SFAC_MODE_SOCKET)
                   | (prog_mode == `SFAC_MODE_ICP);          // [R4] [R5]
    wire ok_prog   = c_prog & chk_ok;                        // [R2] [R12]
    wire ok_sera   = c_sera & chk_ok;                        // [R3] [R12]
    wire ok_mera   = c_mera & tool_mode;                     // [R1]
    wire ok_optw   = c_optw & tool_mode;                     // [R4]
    wire unprot    = protect & ~opt_pending[`SFAC_BIT_PROTECT];
    wire refused   = any_cmd & ~(ok_prog | ok_sera | ok_mera | ok_optw);

    // =================================================================
    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ok_optw && unprot) begin
                    next_state = ST_MERA;                    // [R11]
                end else if (ok_optw) begin
                    next_state = ST_OPTW;
                end else if (ok_mera) begin
                    next_state = ST_MERA;                    // [R1]
                end else if (ok_sera) begin
                    next_state = ST_SERA;                    // [R1]
                end else if (ok_prog) begin
                    next_state = ST_PROG;                    // [R2]
                end
            end
            ST_MERA: begin
                if (flash_done && opt_after_erase) begin
                    next_state = ST_OPTW;                    // [R11]
                end else if (flash_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PROG, ST_SERA, ST_OPTW: begin
                if (flash_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // State register and erase-then-option latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= ST_IDLE;
            opt_after_erase <= 1'b0;
        end else begin
            state <= next_state;
            if (state[0] && ok_optw && unprot) begin
                opt_after_erase <= 1'b1;                     // [R11]
            end else if (state[0]) begin
                opt_after_erase <= 1'b0;
            end
        end
    end

    // =================================================================
    // Flash macro strobes: one-cycle pulses on entering a state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_prog      <= 1'b0;
            flash_erase     <= 1'b0;
            flash_erase_all <= 1'b0;
            flash_opt_prog  <= 1'b0;
            flash_addr      <= 16'h0000;
            flash_wdata     <= `SFAC_RESET_BYTE;
            flash_sector    <= 3'h0;
            flash_opt_data  <= `SFAC_RESET_BYTE;
        end else begin
            flash_prog      <= (next_state == ST_PROG) & state[0];
            flash_erase     <= (next_state == ST_SERA) & state[0];
            flash_erase_all <= (next_state == ST_MERA) & state[0];
            flash_opt_prog  <= (next_state == ST_OPTW)
                             & (state[0] | (state == ST_MERA));
            if (state[0] && any_cmd) begin
                flash_addr   <= {addr_hi, addr_lo};          // [R2]
                flash_wdata  <= wr_data;
                flash_sector <= chk_sector;                  // [R3]
            end
            if (next_state == ST_OPTW) begin
                flash_opt_data <= opt_pending;
            end
        end
    end

    // =================================================================
    // Unlock key sequence, relocks after any command attempt
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_stage <= 2'h0;
        end else if (wr_en && hit_fcsr) begin
            if (unlocked || busy) begin
                key_stage <= 2'h0;                           // [R10]
            end else if (key_stage == 2'h0 && wbyte == `SFAC_KEY1) begin
                key_stage <= 2'h1;                           // [R10]
            end else if (key_stage == 2'h1 && wbyte == `SFAC_KEY2) begin
                key_stage <= 2'h2;                           // [R10]
            end else begin
                key_stage <= 2'h0;
            end
        end
    end

    // =================================================================
    // Error flag: set by refusal, write 1 to clear, set wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flag <= 1'b0;
        end else if (refused) begin
            err_flag <= 1'b1;                                // [R12]
        end else if (wr_en && hit_fcsr && !unlocked &&
                     wbyte[`SFAC_BIT_ERR]) begin
            err_flag <= 1'b0;
        end
    end

    // =================================================================
    // Address, data and option holding registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_lo     <= `SFAC_RESET_BYTE;
            addr_hi     <= `SFAC_RESET_BYTE;
            wr_data     <= `SFAC_RESET_BYTE;
            opt_pending <= `SFAC_RESET_BYTE;
        end else if (wr_en && !busy) begin
            if (hit_al) begin
                addr_lo <= wbyte;
            end
            if (hit_ah) begin
                addr_hi <= wbyte;
            end
            if (hit_dat) begin
                wr_data <= wbyte;
            end
            if (hit_opt) begin
                opt_pending <= wbyte;
            end
        end
    end

    // Live option byte, updated once the option write completes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_current            <= `SFAC_RESET_BYTE;
            readout_protect_option <= 1'b0;
        end else begin
            if (state == ST_OPTW && flash_done) begin
                opt_current <= opt_pending;                  // [R11]
            end
            readout_protect_option <= protect;
        end
    end

    // RAM execution select in test mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_exec <= 1'b0;
        end else begin
            ram_exec <= (prog_mode == `SFAC_MODE_ICT);       // [R9]
        end
    end

    // =================================================================
    // Read mux
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (hit_fcsr) begin
            rd_byte[`SFAC_BIT_BUSY]   = busy;
            rd_byte[`SFAC_BIT_ERR]    = err_flag;
            rd_byte[`SFAC_BIT_UNLOCK] = unlocked;
        end else if (hit_al) begin
            rd_byte = addr_lo;
        end else if (hit_ah) begin
            rd_byte = addr_hi;
        end else if (hit_dat) begin
            rd_byte = wr_data;
        end else if (hit_opt) begin
            rd_byte = opt_current;
        end else if (hit_info) begin
            rd_byte = {3'h0, chk_in, 2'h0, prog_mode};
        end
    end

    // APB answer: one wait state, then ready for one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access && !pready && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

endmodule

//--- test/sfac_flash_ctrl_asserts.sv
// Assertions on the ports of the flash access controller
`timescale 1ns/1ps
module sfac_ctrl_chk (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    // Mode and flash link
    input wire [1:0]  prog_mode,
    input wire        flash_done,
    input wire [15:0] flash_addr,
    input wire [2:0]  flash_sector,
    input wire        flash_prog,
    input wire        flash_erase,
    input wire        flash_erase_all,
    input wire        flash_opt_prog,
    input wire        ram_exec
);
    // =====================================================
    // Helper logic
    wire [3:0] strb = {flash_opt_prog, flash_erase_all,
                       flash_erase, flash_prog};
    wire [2:0] sec_x = (flash_addr[15:12] == 4'hf) ? 3'h1 :
                       (flash_addr[15:12] == 4'he) ? 3'h2 :
                       flash_addr[15] ? 3'h4 : 3'h0;
    reg        busy_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence acc_s; psel && penable; endsequence

    // Outstanding operation tracker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (|strb) begin
            busy_q <= 1'b1;
        end else if (flash_done) begin
            busy_q <= 1'b0;
        end
    end

    // =====================================================
    // Properties
    ready_wait_a: assert property (setup_s ##1 acc_s |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside completion");
    one_op_a: assert property (|strb |-> $onehot(strb) && !busy_q)
        else $error("overlapping flash operations");
    strobe_pulse_a: assert property (|strb |=> strb == 4'h0)
        else $error("strobe longer than one cycle");
    iap_guard_a: assert property ((flash_prog || flash_erase) &&
        prog_mode == 2'h2 |-> !flash_sector[0])
        else $error("sector 0 changed in application mode");
    test_quiet_a: assert property (prog_mode == 2'h3 &&
        $past(prog_mode) == 2'h3 |-> strb == 4'h0)
        else $error("flash changed in test mode");
    mass_mode_a: assert property (flash_erase_all || flash_opt_prog
        |-> prog_mode < 2'h2)
        else $error("mass or option change in wrong mode");
    sector_map_a: assert property ((flash_prog || flash_erase)
        |-> flash_sector == sec_x && sec_x != 3'h0)
        else $error("sector select does not match address");
    ram_follow_a: assert property (1'b1 |=>
        ram_exec == ($past(prog_mode) == 2'h3))
        else $error("ram execution flag wrong");
endmodule

bind sfac_flash_ctrl sfac_ctrl_chk chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prog_mode(prog_mode),
    .flash_done(flash_done), .flash_addr(flash_addr),
    .flash_sector(flash_sector), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_erase_all(flash_erase_all),
    .flash_opt_prog(flash_opt_prog), .ram_exec(ram_exec)
);

//--- test/sfac_flash_model.sv
// Behavioural flash macro answering each strobe after a latency
`timescale 1ns/1ps
module sfac_flash_model (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Strobe and latency
    input  wire       go,
    input  wire [3:0] lat,
    // Completion
    output reg        flash_done
);
    // =====================================================
    // Latency counter
    reg [3:0] cnt;
    reg       run;

    // One byte or one erase per strobe, done when count expires
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run        <= 1'b0;
            cnt        <= 4'h0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            if (go) begin
                run <= 1'b1;
                cnt <= lat;
            end else if (run && cnt == 4'h0) begin
                run        <= 1'b0;
                flash_done <= 1'b1;
            end else if (run) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

//--- test/sectored_flash_access_control_test.sv
// Self-checking bench for the flash access controller
`timescale 1ns/1ps
`include "sfac_defines.vh"
module sectored_flash_access_control_test;
    // =====================================================
    // Signals
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [1:0]  prog_mode = 2'h0;
    reg  [3:0]  lat = 4'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, flash_done, flash_prog, flash_erase;
    wire        flash_erase_all, flash_opt_prog, ram_exec, prot;
    wire [15:0] flash_addr;
    wire [7:0]  flash_wdata, flash_opt_data;
    wire [2:0]  flash_sector;
    wire [3:0]  strb = {flash_opt_prog, flash_erase_all,
                        flash_erase, flash_prog};
    integer     error_cnt = 0;
    integer     compares = 0;
    integer     seed = 27;
    integer     m, a, c;
    reg         prot_x = 1'b0;
    reg  [15:0] addr;
    reg  [7:0]  dat;
    reg  [9:0]  re;
    reg  [25:0] se;
    reg  [9:0]  rdq[$];
    reg  [25:0] stq[$];

    // Clock
    always #5 pclk = ~pclk;

    sfac_flash_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .prog_mode(prog_mode),
        .flash_done(flash_done), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata), .flash_sector(flash_sector),
        .flash_prog(flash_prog), .flash_erase(flash_erase),
        .flash_erase_all(flash_erase_all), .flash_opt_prog(flash_opt_prog),
        .flash_opt_data(flash_opt_data), .ram_exec(ram_exec),
        .readout_protect_option(prot)
    );
    sfac_flash_model flash (
        .pclk(pclk), .presetn(presetn), .go(|strb), .lat(lat),
        .flash_done(flash_done)
    );

    // =====================================================
    // Tasks
    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            compares++;
            if (e !== s) begin
                error_cnt++;
                $display("mismatch %s expected %h seen %h", nm, e, s);
            end
        end
    endtask

    // One APB transfer; expectation queued for the monitor
    task apb(input w, input [7:0] idx, input [7:0] d, input er, input [7:0] ed);
        begin
            rdq.push_back({w, er, ed});
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {2'h0, idx, 2'h0};
            pwdata <= {24'h0, d};
            @(posedge pclk) penable <= 1'b1;
            @(posedge pclk);
            while (!pready) @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Unlocked command; kd 0 prog, 1 sector erase, 2 mass, 3 option
    task op(input [7:0] cmd, input [15:0] ad, input [7:0] d, input [1:0] kd);
        reg ok;
        integer n;
        begin
            ok = (kd < 2) ? (ad[15] && prog_mode != 2'h3 && !prot_x &&
                 !(prog_mode == 2'h2 && ad[15:12] == 4'hf)) : (prog_mode < 2'h2);
            n = ok ? 1 : 0;
            apb(1, `SFAC_IDX_ADDRL, ad[7:0], 0, 0);
            apb(1, `SFAC_IDX_ADDRH, ad[15:8], 0, 0);
            apb(0, `SFAC_IDX_INFO, 0, 0,
                {3'h0, ad[15], 2'h0, prog_mode});
            apb(1, `SFAC_IDX_DATA, d, 0, 0);
            apb(1, `SFAC_IDX_OPT, d, 0, 0);
            apb(1, `SFAC_IDX_FCSR, `SFAC_KEY1, 0, 0);
            apb(1, `SFAC_IDX_FCSR, `SFAC_KEY2, 0, 0);
            if (ok && kd == 2'h3 && prot_x && !d[0]) begin
                stq.push_back({2'h2, ad, d});
                n = 2;
            end
            if (ok) stq.push_back({kd, ad, d});
            if (ok && kd == 2'h3) prot_x = d[0];
            apb(1, `SFAC_IDX_FCSR, cmd, 0, 0);
            repeat (n) begin
                @(posedge pclk);
                while (!flash_done) @(posedge pclk);
            end
            apb(0, `SFAC_IDX_FCSR, 0, 0, ok ? 8'h00 : 8'h20);
            if (!ok) apb(1, `SFAC_IDX_FCSR, 8'h20, 0, 0);
            chk("protect", 32'(prot_x), 32'(prot));
        end
    endtask

    task print_verdict;
        begin
            $display("compares %0d error_cnt %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask

    // =====================================================
    // Monitor: APB completions and flash strobes
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            re = rdq.pop_front();
            chk("pslverr", 32'(re[8]), 32'(pslverr));
            if (!re[9]) chk("prdata", 32'(re[7:0]), prdata);
        end
        if (strb != 4'h0 && stq.size() == 0) begin
            chk("strobe", 32'h0, 32'(strb));
        end else if (strb != 4'h0) begin
            se = stq.pop_front();
            chk("strobe", 32'(4'h1 << se[25:24]),
                32'(strb));
            if (!se[25]) chk("flash_addr", 32'(se[23:8]),
                32'(flash_addr));
            if (!se[25]) chk("sector", (se[23:20] == 4'hf) ? 1 :
                (se[23:20] == 4'he) ? 2 : 4,
                32'(flash_sector));
            if (se[25:24] == 2'h0) chk("wdata", 32'(se[7:0]),
                32'(flash_wdata));
            if (se[25:24] == 2'h3) chk("opt", 32'(se[7:0]),
                32'(flash_opt_data));
        end
    end

    // Watchdog
    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end

    // =====================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SFAC_IDX_FCSR, 0, 0, `SFAC_RESET_BYTE);
        apb(0, `SFAC_IDX_OPT, 0, 0, 8'h00);
        apb(0, `SFAC_IDX_INFO, 0, 0, 8'h00);
        apb(0, 8'h10, 0, 1, 8'h00);
        apb(1, `SFAC_IDX_FCSR, 8'h01, 0, 0);
        apb(0, `SFAC_IDX_FCSR, 0, 0, 8'h00);
        apb(1, `SFAC_IDX_FCSR, 8'h20, 0, 0);
        $display("test reset and lock done");
        for (m = 0; m < 4; m++) begin
            prog_mode <= m[1:0];
            repeat (2) @(posedge pclk);
            chk("ram_exec", 32'(m == 3), 32'(ram_exec));
            for (a = 0; a < 4; a++) begin
                addr = (a == 0) ? 16'hf000 : (a == 1) ? 16'he000 : {a[0], 15'h0};
                addr[11:0] = $random(seed);
                dat = $random(seed);
                lat <= $random(seed);
                for (c = 0; c < 2; c++) op(8'h01 << c, addr, dat, c[1:0]);
            end
            op(8'h04, addr, dat, 2'h2);
            op(8'h08, addr, dat & 8'hfe, 2'h3);
        end
        $display("test modes and sectors done");
        prog_mode <= 2'h0;
        @(posedge pclk);
        op(8'h08, 16'hf000, 8'h01, 2'h3);
        op(8'h01, 16'hf000, 8'h5a, 2'h0);
        op(8'h08, 16'hf000, 8'h00, 2'h3);
        apb(0, `SFAC_IDX_OPT, 0, 0, 8'h00);
        chk("pending", 0, stq.size());
        $display("test protection removal done");
        print_verdict;
    end
endmodule
